// ---- design/mps_regs.svh ----
// register map, field positions, reset values and rule summary of the pattern sequencer
// Summary of operation
// - a 3-bit transfer mode field picks which event makes the write strobe; full-word buffer 0 writes strobe in every mode.
// - mode 000: software write to buffer 0 strobes; output updates one cycle later.
// - mode 000 always copies buffer 0, ignoring bank flag and next index.
// - mode 000: only full-word buffer 0 writes start a transfer, byte writes do not.
// - mode 001: every reload timer underflow strobes, however the timer was started.
// - modes 010 and 110: strobe comes straight from the position detector.
// - each position input is compared with its own next-index bit; full match copies.
// - modes 011 and 111: detection starts the timer; each later underflow strobes.
// - modes 100 and 101: detection or timer underflow, whichever comes, strobes.
// - the position comparison is evaluated only on an effective input edge.
// - twelve pattern buffers, each upper and lower half laid out like the output.
// - outside mode 000 an event strobe copies the buffer named by the held bank and index (none for 12 to 15); a buffer 0 write copies buffer 0.
// - each buffer carries its own bank and index, so transfers chain automatically.
// - writing buffer 0 initialises the output pattern register.
// - after a mode change the next copy uses the bank and index already held.
// - modes 000 and 010 never use the reload timer.
// - select pair per output: 00 low, 01 PPG, 10 inverted PPG, 11 high.
// - one-shot modes ignore further detections until a different mode is selected.
// - delay modes use single-shot timer; its pulse must exceed two cycles.
// - polarity 01 rising, 10 falling, 11 both; 00 with compare enable is prohibited.
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define MPS_OFS_CTRL 8'h00
`define MPS_OFS_INCTL 8'h04
`define MPS_OFS_PAT 8'h08
`define MPS_OFS_STAT 8'h0C
`define MPS_OFS_BUF0 8'h40
`define MPS_NUM_BUF 12
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MPS_CTRL_MODE_LO 0
`define MPS_INCTL_COMPARE_ENABLE 0
`define MPS_INCTL_POL_LO 1
`define MPS_INCTL_EDGE_LO 3
`define MPS_PAT_BANK 15
`define MPS_PAT_IDX_LO 12
`define MPS_STAT_LOCK 3
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MPS_RST_MODE 3'h0
`define MPS_RST_POL 2'h0
`define MPS_RST_EDGE 3'h0
`define MPS_RST_PAT 16'h0000
`endif

// ---- design/mps_pkg.sv ----
// types of the pattern sequencer
package mps_pkg;
  typedef enum logic [2:0] {
    MPS_MODE_BUF0 = 3'h0, MPS_MODE_TMR = 3'h1, MPS_MODE_POS = 3'h2, MPS_MODE_POS_DLY = 3'h3,
    MPS_MODE_POS_OR = 3'h4, MPS_MODE_ONE_OR = 3'h5, MPS_MODE_ONE_POS = 3'h6,
    MPS_MODE_ONE_DLY = 3'h7
  } mps_mode_t;
  typedef struct packed {
    logic [2:0] prev;
    logic hit;
  } mps_det_state_t;
  typedef struct packed {
    logic [5:0] pins;
  } mps_out_state_t;
  typedef struct packed {
    mps_mode_t mode;
    logic compare_enable;
    logic [1:0] pol;
    logic [2:0] edge_en;
    logic [15:0] pat;
    logic [11:0][15:0] bufs;
    logic ack;
    logic [31:0] dat;
    logic strobe;
    logic force0;
    logic lock;
    logic tprev;
    logic tstart;
  } mps_state_t;
endpackage : mps_pkg

// ---- design/mps_posdet.sv ----
// position detector: effective edge and input/index comparison
`timescale 1ns/100ps
module mps_posdet (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] position_inputs_i,
  input wire logic [2:0] next_index_bits_i,
  input wire logic compare_enable_i,
  input wire logic [1:0] edge_polarity_select_i,
  input wire logic [2:0] edge_enable_i,
  output logic position_write_trigger_o
);
  import mps_pkg::*;
  mps_det_state_t s_reg;
  mps_det_state_t s_next;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] eff;

  always_comb begin
    s_next = s_reg;
    rise = position_inputs_i & ~s_reg.prev;
    fall = ~position_inputs_i & s_reg.prev;
    eff = (rise & {3{edge_polarity_select_i[0]}}) | (fall & {3{edge_polarity_select_i[1]}});
    s_next.prev = position_inputs_i;
    if (compare_enable_i) begin
      s_next.hit = (|eff) && (position_inputs_i == next_index_bits_i);
    end else begin
      s_next.hit = |(eff & edge_enable_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign position_write_trigger_o = s_reg.hit;
endmodule : mps_posdet

// ---- design/mps_outsel.sv ----
// pulse output selector: each output follows its select pair
`timescale 1ns/100ps
module mps_outsel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] select_pairs_i,
  input wire logic ppg_i,
  output logic [5:0] pulse_outputs_o
);
  import mps_pkg::*;
  mps_out_state_t s_reg;
  mps_out_state_t s_next;

  function automatic logic pick(input logic [1:0] pair, input logic ppg);
    unique case (pair)
      2'h0: pick = 1'b0;
      2'h1: pick = ppg;
      2'h2: pick = ~ppg;
      2'h3: pick = 1'b1;
    endcase
  endfunction : pick

  always_comb begin
    s_next = s_reg;
    for (int k = 0; k < 6; k++) begin
      s_next.pins[k] = pick(select_pairs_i[2*k +: 2], ppg_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pulse_outputs_o = s_reg.pins;
endmodule : mps_outsel

// ---- design/mps_sequencer.sv ----
// pattern transfer sequencer with wishbone register access
`include "mps_regs.svh"
`timescale 1ns/100ps
module mps_sequencer (
  input wire logic clk_i,
  input wire logic rst_i,
  // ----------------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------------
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // ----------------------------------------------------------------------
  // position sensors, reload timer and ppg
  // ----------------------------------------------------------------------
  input wire logic [2:0] position_inputs_i,
  input wire logic timer_pulse_output_i,
  input wire logic ppg_i,
  output logic timer_start_o,
  output logic write_strobe_o,
  output mps_pkg::mps_mode_t transfer_mode_select_o,
  output logic [15:0] output_pattern_o,
  output logic [5:0] pulse_outputs_o
);
  import mps_pkg::*;

  mps_state_t s_reg;
  mps_state_t s_next;
  logic position_write_trigger;
  logic underflow_write_trigger;
  logic pos_ok;
  logic req;
  logic wr_now;
  logic buffer0_write_signal;
  logic event_strobe;
  logic [3:0] copy_index;
  logic [5:0] word_index;
  logic [3:0] buf_slot;
  logic buf_hit;
  logic one_shot;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // both halves of a 16-bit register written at once
  function automatic logic full_word(input logic [3:0] sel);
    full_word = (sel[1:0] == 2'h3);
  endfunction : full_word

  // merge write data into a 16-bit register by byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  // one-shot modes lock position detection after the first hit
  function automatic logic is_one_shot(input mps_mode_t m);
    is_one_shot = (m == MPS_MODE_ONE_OR) || (m == MPS_MODE_ONE_POS) || (m == MPS_MODE_ONE_DLY);
  endfunction : is_one_shot

  // ----------------------------------------------------------------------
  // position detector and output selector
  // ----------------------------------------------------------------------
  mps_posdet u_posdet (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .position_inputs_i(position_inputs_i),
    .next_index_bits_i(s_reg.pat[`MPS_PAT_IDX_LO +: 3]),
    .compare_enable_i(s_reg.compare_enable),
    .edge_polarity_select_i(s_reg.pol),
    .edge_enable_i(s_reg.edge_en),
    .position_write_trigger_o(position_write_trigger)
  );

  mps_outsel u_outsel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .select_pairs_i(s_reg.pat[11:0]),
    .ppg_i(ppg_i),
    .pulse_outputs_o(pulse_outputs_o)
  );

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  assign req = cyc_i && stb_i;
  assign wr_now = req && we_i && s_reg.ack;
  assign word_index = adr_i[7:2];
  assign buf_slot = 4'(word_index - 6'(`MPS_OFS_BUF0 >> 2));
  assign buf_hit = (word_index >= 6'(`MPS_OFS_BUF0 >> 2)) &&
                   (word_index < 6'((`MPS_OFS_BUF0 >> 2) + `MPS_NUM_BUF));
  // only a full-word write to buffer 0 counts as a buffer 0 write
  assign buffer0_write_signal = wr_now && buf_hit && (buf_slot == 4'h0) &&
                                full_word(sel_i);

  // ----------------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------------
  // timer pulse is caught on its rising edge, one transfer per pulse
  assign underflow_write_trigger = timer_pulse_output_i && !s_reg.tprev;
  assign one_shot = is_one_shot(s_reg.mode);
  assign pos_ok = position_write_trigger && !(one_shot && s_reg.lock);
  assign copy_index = {s_reg.pat[`MPS_PAT_BANK], s_reg.pat[`MPS_PAT_IDX_LO +: 3]};

  // the mode field alone chooses the strobe source
  always_comb begin
    event_strobe = 1'b0;
    unique case (s_reg.mode)
      MPS_MODE_BUF0: begin
        event_strobe = 1'b0;
      end
      MPS_MODE_TMR: begin
        event_strobe = underflow_write_trigger;
      end
      MPS_MODE_POS, MPS_MODE_ONE_POS: begin
        event_strobe = pos_ok;
      end
      MPS_MODE_POS_DLY, MPS_MODE_ONE_DLY: begin
        event_strobe = underflow_write_trigger;
      end
      MPS_MODE_POS_OR, MPS_MODE_ONE_OR: begin
        event_strobe = pos_ok || underflow_write_trigger;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.tprev = timer_pulse_output_i;

    // wishbone: ack one cycle after the request, dropped the cycle after
    s_next.ack = req && !s_reg.ack;
    if (req && !s_reg.ack) begin
      s_next.dat = 32'h0000_0000;
      if (buf_hit) begin
        s_next.dat = {16'h0000, s_reg.bufs[buf_slot]};
      end else begin
        unique case (adr_i)
          `MPS_OFS_CTRL: begin
            s_next.dat = {29'h0000_0000, s_reg.mode};
          end
          `MPS_OFS_INCTL: begin
            s_next.dat = {26'h000_0000, s_reg.edge_en, s_reg.pol, s_reg.compare_enable};
          end
          `MPS_OFS_PAT: begin
            s_next.dat = {16'h0000, s_reg.pat};
          end
          `MPS_OFS_STAT: begin
            s_next.dat = {22'h00_0000, pulse_outputs_o, s_reg.lock, position_inputs_i};
          end
          default: begin
            s_next.dat = 32'h0000_0000;
          end
        endcase
      end
    end

    // timer start only in the delay modes
    s_next.tstart = pos_ok && ((s_reg.mode == MPS_MODE_POS_DLY) ||
                               (s_reg.mode == MPS_MODE_ONE_DLY));

    // one-shot lock: first valid detection locks, a mode change unlocks
    if (one_shot && pos_ok) begin
      s_next.lock = 1'b1;
    end

    // register writes at the acknowledging edge
    if (wr_now) begin
      if (buf_hit) begin
        s_next.bufs[buf_slot] = merge16(s_reg.bufs[buf_slot], dat_i, sel_i);
      end else begin
        unique case (adr_i)
          `MPS_OFS_CTRL: begin
            if (sel_i[0]) begin
              s_next.mode = mps_mode_t'(dat_i[`MPS_CTRL_MODE_LO +: 3]);
              if (dat_i[`MPS_CTRL_MODE_LO +: 3] != s_reg.mode) begin
                s_next.lock = 1'b0;
              end
            end
          end
          `MPS_OFS_INCTL: begin
            if (sel_i[0]) begin
              s_next.compare_enable = dat_i[`MPS_INCTL_COMPARE_ENABLE];
              s_next.pol = dat_i[`MPS_INCTL_POL_LO +: 2];
              s_next.edge_en = dat_i[`MPS_INCTL_EDGE_LO +: 3];
            end
          end
          `MPS_OFS_PAT: begin
            // byte writes are dropped so the chain link stays whole
            if (full_word(sel_i)) begin
              s_next.pat = dat_i[15:0];
            end
          end
          default: begin
            s_next.dat = s_reg.dat;
          end
        endcase
      end
    end

    // one-clock strobe, copy at the following edge
    s_next.force0 = buffer0_write_signal;
    s_next.strobe = buffer0_write_signal || event_strobe;

    if (s_reg.strobe) begin
      if (s_reg.force0 || (s_reg.mode == MPS_MODE_BUF0)) begin
        s_next.pat = s_reg.bufs[0];
      end else if (copy_index < 4'(`MPS_NUM_BUF)) begin
        // held bank and index pick the source, which carries the next link
        s_next.pat = s_reg.bufs[copy_index];
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.mode <= mps_mode_t'(`MPS_RST_MODE);
      s_reg.pol <= `MPS_RST_POL;
      s_reg.edge_en <= `MPS_RST_EDGE;
      s_reg.pat <= `MPS_RST_PAT;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign dat_o = s_reg.dat;
  assign ack_o = s_reg.ack;
  assign timer_start_o = s_reg.tstart;
  assign write_strobe_o = s_reg.strobe;
  assign transfer_mode_select_o = s_reg.mode;
  assign output_pattern_o = s_reg.pat;
endmodule : mps_sequencer

// ---- dv/mps_sequencer_sva.sv ----
// port checker of the pattern sequencer
`timescale 1ns/100ps
module mps_sequencer_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic timer_pulse_output_i,
  input wire logic ppg_i,
  input wire logic timer_start_o,
  input wire logic write_strobe_o,
  input wire mps_pkg::mps_mode_t transfer_mode_select_o,
  input wire logic [15:0] output_pattern_o,
  input wire logic [5:0] pulse_outputs_o
);
  import mps_pkg::*;
  mps_mode_t m;
  logic wr0, wr0_d, tprev, trise_d, seen, dly, dly_d;
  logic [5:0] drv;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign m = transfer_mode_select_o;
  // delay modes 011 and 111 share the low bits 11
  assign dly = m[1:0] == 2'h3;
  assign wr0 = cyc_i && stb_i && we_i && ack_o && adr_i[7:2] == 6'h10 && sel_i[1:0] == 2'h3;
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      case (output_pattern_o[2*k+:2])
        2'h0: drv[k] = 1'h0;
        2'h1: drv[k] = ppg_i;
        2'h2: drv[k] = !ppg_i;
        default: drv[k] = 1'h1;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {wr0_d, tprev, trise_d, seen, dly_d} <= 5'h0;
    end else begin
      wr0_d <= wr0;
      tprev <= timer_pulse_output_i;
      trise_d <= timer_pulse_output_i && !tprev;
      dly_d <= dly;
      // mode 110 detection seen; any mode change clears it
      seen <= (m == MPS_MODE_ONE_POS) && (seen || (write_strobe_o && !wr0_d)) && !$changed(m);
    end
  end
  property p_ack_req; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_buf0; wr0 |=> write_strobe_o ##1 output_pattern_o == $past(dat_i[15:0], 2); endproperty
  a_buf0: assert property (p_buf0) else $error("buffer 0 copy");
  property p_byte;
    m == MPS_MODE_BUF0 && ack_o && we_i && adr_i[7:2] == 6'h10 && sel_i[1:0] != 2'h3
      |=> !write_strobe_o;
  endproperty
  a_byte: assert property (p_byte) else $error("byte write strobed");
  property p_mode0_tmr; m == MPS_MODE_BUF0 && $rose(timer_pulse_output_i) && !ack_o
    |=> !write_strobe_o; endproperty
  a_mode0_tmr: assert property (p_mode0_tmr) else $error("timer strobed");
  property p_tmr; !(m inside {MPS_MODE_BUF0, MPS_MODE_POS, MPS_MODE_ONE_POS})
    && $rose(timer_pulse_output_i) |=> write_strobe_o; endproperty
  a_tmr: assert property (p_tmr) else $error("underflow lost");
  property p_start; !dly && !dly_d |-> !timer_start_o; endproperty
  a_start: assert property (p_start) else $error("timer started");
  property p_dly; dly && write_strobe_o |-> trise_d || wr0_d; endproperty
  a_dly: assert property (p_dly) else $error("strobe not from timer");
  property p_lock; m == MPS_MODE_ONE_POS && seen |-> !write_strobe_o || wr0_d; endproperty
  a_lock: assert property (p_lock) else $error("second detection");
  property p_out; 1'h1 |=> pulse_outputs_o == $past(drv); endproperty
  a_out: assert property (p_out) else $error("pulse outputs");
endmodule : mps_sequencer_sva

// ---- dv/mps_partner.sv ----
// position sensors and reload timer beside the sequencer
`timescale 1ns/100ps
module mps_partner #(
  parameter int RELOAD = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic timer_start_i,
  input wire logic sw_start_i,
  input wire logic reload_i,
  input wire logic [2:0] pos_set_i,
  output logic [2:0] position_inputs_o,
  output logic timer_pulse_output_o
);
  int cnt;
  int hold;
  logic run;
  assign timer_pulse_output_o = hold > 0;
  always_ff @(posedge clk_i) begin
    position_inputs_o <= pos_set_i;
    if (rst_i) begin
      run <= 1'h0;
      cnt <= 0;
      hold <= 0;
    end else begin
      hold <= (hold > 0) ? hold - 1 : 0;
      if (timer_start_i || sw_start_i) begin
        run <= 1'h1;
        cnt <= RELOAD;
      end else if (run && cnt == 0) begin
        hold <= 3;
        run <= reload_i;
        cnt <= RELOAD;
      end else if (run) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : mps_partner

// ---- dv/mps_sequencer_tb_top.sv ----
// self-checking bench of the pattern sequencer
`timescale 1ns/100ps
module mps_sequencer_tb_top;
  import mps_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ppg, sw_start, reload, ack_o, tpulse, tstart, wstrobe;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, rd;
  logic [2:0] pos_set, pos;
  logic [15:0] pat;
  logic [15:0] bufv [12];
  logic [5:0] pout;
  mps_mode_t mode_o;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_strobe = 0;
  int exp_str = 0;
  mps_sequencer i_mps_sequencer (
    .clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o, .ack_o, .position_inputs_i(pos), .timer_pulse_output_i(tpulse), .ppg_i(ppg),
    .timer_start_o(tstart), .write_strobe_o(wstrobe), .transfer_mode_select_o(mode_o),
    .output_pattern_o(pat), .pulse_outputs_o(pout)
  );
  mps_partner #(.RELOAD(20)) i_mps_partner (
    .clk_i, .rst_i, .timer_start_i(tstart), .sw_start_i(sw_start), .reload_i(reload),
    .pos_set_i(pos_set), .position_inputs_o(pos), .timer_pulse_output_o(tpulse)
  );
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (wstrobe === 1'h1) begin
      n_strobe <= n_strobe + 1;
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, s, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'h1 && t < 20);
    rd = dat_o;
    chk("ack", ack_o, 1'h1);
    {cyc, stb, we} <= 3'h0;
  endtask : wb
  task automatic set_mode(input mps_mode_t md);
    wb(1'h1, 8'h00, 4'h1, 32'(md));
    wb(1'h0, 8'h00, 4'hF, 32'h0);
    chk("mode", rd, 32'(md));
    chk("mode port", 32'(mode_o), 32'(md));
  endtask : set_mode
  // move the sensors and maybe kick the timer, then count strobes and check the pattern
  task automatic step(input string name, input logic [2:0] p, input logic k, input int ds,
                      input logic [15:0] ep);
    {pos_set, sw_start, ppg} <= {p, k, !ppg};
    @(posedge clk_i);
    sw_start <= 1'h0;
    repeat (40) @(posedge clk_i);
    exp_str += ds;
    chk("strobe count", n_strobe, exp_str);
    chk("pattern", pat, ep);
    $display("test %s done", name);
  endtask : step
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (6000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end
  initial begin
    int t;
    rst_i = 1'h1;
    {cyc, stb, we, ppg, sw_start, reload, adr, sel, dat, pos_set} = '0;
    for (int i = 0; i < 12; i++) begin
      bufv[i] = {4'((i % 11) + 1), 12'(i * 37 + 5)};
    end
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h1, 8'h10, 4'hF, 32'hFFFFFFFF);
    for (int a = 0; a < 5; a++) begin
      wb(1'h0, 8'(a * 4), 4'hF, 32'h0);
      chk("reset read", rd, 32'h0);
    end
    for (int i = 1; i < 12; i++) begin
      wb(1'h1, 8'h40 + 8'(i * 4), 4'hF, 32'(bufv[i]));
    end
    wb(1'h1, 8'h40, 4'h2, 32'h0000FFFF);
    step("byte write", 3'h0, 1'h0, 0, 16'h0);
    step("timer in mode 000", 3'h0, 1'h1, 0, 16'h0);
    for (int j = 0; j < 2; j++) begin
      wb(1'h1, 8'h40, 4'h3, 32'(bufv[0]));
      step("buffer 0 write", 3'h0, 1'h0, 1, bufv[0]);
      bufv[0] = bufv[0] ^ 16'h0F0F;
    end
    set_mode(MPS_MODE_TMR);
    {reload, sw_start} <= 2'h3;
    @(posedge clk_i);
    sw_start <= 1'h0;
    for (int i = 1; i < 13; i++) begin
      t = 0;
      do begin
        @(posedge clk_i);
        t++;
      end while (wstrobe !== 1'h1 && t < 60);
      repeat (2) @(posedge clk_i);
      exp_str++;
      chk("chained pattern", pat, bufv[(i - 1) % 11 + 1]);
    end
    reload <= 1'h0;
    step("last underflow", 3'h0, 1'h0, 1, bufv[2]);
    wb(1'h1, 8'h08, 4'h3, 32'h0000C000);
    step("unused index", 3'h0, 1'h1, 1, 16'hC000);
    wb(1'h1, 8'h08, 4'h1, 32'h000000FF);
    wb(1'h0, 8'h08, 4'hF, 32'h0);
    chk("pattern after byte write", rd, 32'h0000C000);
    wb(1'h1, 8'h08, 4'h3, 32'h00003000);
    set_mode(MPS_MODE_POS);
    wb(1'h1, 8'h04, 4'h1, 32'h00000007);
    step("no match", 3'h2, 1'h0, 0, 16'h3000);
    step("match", 3'h3, 1'h0, 1, bufv[3]);
    step("steady inputs", 3'h3, 1'h1, 0, bufv[3]);
    step("next match", 3'h4, 1'h0, 1, bufv[4]);
    set_mode(MPS_MODE_ONE_POS);
    step("one-shot", 3'h5, 1'h0, 1, bufv[5]);
    step("one-shot locked", 3'h6, 1'h0, 0, bufv[5]);
    wb(1'h0, 8'h0C, 4'hF, 32'h0);
    chk("lock flag set", 32'(rd[3]), 32'h1);
    set_mode(MPS_MODE_POS);
    step("unlocked no match", 3'h2, 1'h0, 0, bufv[5]);
    step("unlocked match", 3'h6, 1'h0, 1, bufv[6]);
    set_mode(MPS_MODE_POS_DLY);
    step("delay", 3'h7, 1'h0, 1, bufv[7]);
    set_mode(MPS_MODE_POS_OR);
    step("or timer", 3'h7, 1'h1, 1, bufv[8]);
    step("or position", 3'h1, 1'h0, 1, bufv[9]);
    set_mode(MPS_MODE_ONE_OR);
    step("one-shot or position", 3'h2, 1'h0, 1, bufv[10]);
    step("one-shot or locked", 3'h3, 1'h0, 0, bufv[10]);
    step("one-shot or timer", 3'h3, 1'h1, 1, bufv[11]);
    set_mode(MPS_MODE_ONE_DLY);
    step("one-shot delay", 3'h1, 1'h0, 1, bufv[1]);
    step("one-shot delay locked", 3'h2, 1'h0, 0, bufv[1]);
    set_mode(MPS_MODE_POS);
    wb(1'h0, 8'h0C, 4'hF, 32'h0);
    chk("lock flag cleared", 32'(rd[3]), 32'h0);
    // edge mode without compare: rising edges of input 0 only
    wb(1'h1, 8'h04, 4'h1, 32'h0000000A);
    step("rising edge", 3'h3, 1'h0, 1, bufv[2]);
    step("falling edge", 3'h2, 1'h0, 0, bufv[2]);
    step("edge not enabled", 3'h6, 1'h0, 0, bufv[2]);
    conclude();
  end
endmodule : mps_sequencer_tb_top
bind mps_sequencer mps_sequencer_sva i_mps_sequencer_sva (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .timer_pulse_output_i,
  .ppg_i, .timer_start_o, .write_strobe_o, .transfer_mode_select_o, .output_pattern_o,
  .pulse_outputs_o
);
